// ---- hw/lpmc_top.sv ----
/*
 * lpmc_top: low power mode controller with clock dividers, module stop,
 * operating power control mode and per-register security attributes.
 * Assumes core, interrupt and reset sources share clk; snooze_trig is a pin.
 */
`timescale 1ns/1ps

module lpmc_top (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rstn,
    // core and event sources
    input  wire logic                           wfi,
    input  wire logic                           irq_any,
    input  wire logic                           irq_sby_wake,
    input  wire logic                           irq_dsby_wake,
    input  wire logic                           rst_src,
    input  wire logic                           snooze_trig,
    input  wire logic                           snooze_end,
    // register writes
    input  wire logic [lpmc_pkg::NUM_REG-1:0]   cfg_wr,
    input  wire logic                           cfg_secure,
    input  wire logic [lpmc_pkg::NUM_REG-1:0]   sec_attr,
    input  wire logic                           standby_select,
    input  wire logic                           deep_standby_select,
    input  wire logic                           snooze_enable,
    input  wire logic [1:0]                     power_control_mode,
    input  wire logic [lpmc_pkg::DIV_W-1:0]     div_sel [lpmc_pkg::NUM_CLK],
    input  wire logic [lpmc_pkg::NUM_MOD-1:0]   module_stop,
    input  wire logic [lpmc_pkg::NUM_OSC-1:0]   osc_req,
    // status
    output lpmc_pkg::lpmc_state_t               lpm_state,
    output lpmc_pkg::lpmc_opc_t                 opc_mode,
    output logic                                core_halt,
    output logic                                irq_resume,
    output logic                                sys_reset,
    // clocks, modules and oscillators
    output logic [lpmc_pkg::NUM_CLK-1:0]        clk_tick,
    output logic [lpmc_pkg::NUM_MOD-1:0]        module_run,
    output logic [lpmc_pkg::NUM_OSC-1:0]        osc_en
);

    lpmc_pkg::lpmc_state_t       state_r;
    lpmc_pkg::lpmc_state_t       state_nxt;
    logic                        stby_sel_r;
    logic                        dsby_sel_r;
    logic                        snz_en_r;
    logic [lpmc_pkg::DIV_W-1:0]  div_r [lpmc_pkg::NUM_CLK];
    logic [lpmc_pkg::NUM_MOD-1:0] mstop_r;
    logic [lpmc_pkg::RST_CNT_W-1:0] rst_cnt_r;
    logic                        trig_s1_r;
    logic                        trig_s2_r;
    logic                        trig_d_r;
    logic                        trig_rise;
    logic                        rst_done;
    logic                        periph_on;
    logic [lpmc_pkg::NUM_CLK-1:0] clk_run;
    logic [lpmc_pkg::NUM_OSC-1:0] osc_ok;

    // write allowed when the register is nonsecure or the access is secure
    function automatic logic wr_ok(input logic [lpmc_pkg::NUM_REG-1:0] wr,
                                   input logic [lpmc_pkg::NUM_REG-1:0] attr,
                                   input logic sec, input int idx);
        wr_ok = wr[idx] && (sec || !attr[idx]);
    endfunction

    // ------------------------------------------------------------------
    // snooze trigger synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r  <= 1'b0;
        end else begin
            trig_s1_r <= snooze_trig;
            trig_s2_r <= trig_s1_r;
            trig_d_r  <= trig_s2_r;
        end
    end

    assign trig_rise = trig_s2_r && !trig_d_r;

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stby_sel_r <= 1'b0;
            dsby_sel_r <= 1'b0;
        end else if (wr_ok(cfg_wr, sec_attr, cfg_secure,
                           lpmc_pkg::REG_STBY)) begin
            stby_sel_r <= standby_select;
            dsby_sel_r <= deep_standby_select;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            snz_en_r <= 1'b0;
        end else if (wr_ok(cfg_wr, sec_attr, cfg_secure,
                           lpmc_pkg::REG_SNOOZE)) begin
            snz_en_r <= snooze_enable;
        end
    end

    // reserved encoding is ignored; mode only changes in normal or sleep
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            opc_mode <= lpmc_pkg::LPMC_OPC_HIGH;
        end else if (wr_ok(cfg_wr, sec_attr, cfg_secure, lpmc_pkg::REG_OPC)
                     && (state_r == lpmc_pkg::LPMC_RUN
                         || state_r == lpmc_pkg::LPMC_SLEEP)
                     && power_control_mode != 2'h2) begin
            opc_mode <= lpmc_pkg::lpmc_opc_t'(power_control_mode);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < lpmc_pkg::NUM_CLK; i++) begin
                div_r[i] <= lpmc_pkg::DIV_RST;
            end
            mstop_r <= lpmc_pkg::MSTOP_RST;
        end else if (wr_ok(cfg_wr, sec_attr, cfg_secure,
                           lpmc_pkg::REG_CLK)) begin
            for (int i = 0; i < lpmc_pkg::NUM_CLK; i++) begin
                div_r[i] <= div_sel[i];
            end
            mstop_r <= module_stop;
        end
    end

    // ------------------------------------------------------------------
    // low power state machine
    // ------------------------------------------------------------------
    assign rst_done = rst_cnt_r == lpmc_pkg::RST_CNT_W'(
                      lpmc_pkg::RST_HOLD_CYC - 1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            lpmc_pkg::LPMC_RUN: begin
                if (rst_src) begin
                    state_nxt = lpmc_pkg::LPMC_RESET;
                end else if (wfi) begin
                    if (!stby_sel_r) begin
                        state_nxt = lpmc_pkg::LPMC_SLEEP;
                    end else if (!dsby_sel_r) begin
                        state_nxt = lpmc_pkg::LPMC_SSTBY;
                    end else begin
                        state_nxt = lpmc_pkg::LPMC_DSTBY;
                    end
                end
            end
            lpmc_pkg::LPMC_SLEEP: begin
                if (rst_src) begin
                    state_nxt = lpmc_pkg::LPMC_RESET;
                end else if (irq_any) begin
                    state_nxt = lpmc_pkg::LPMC_RUN;
                end
            end
            lpmc_pkg::LPMC_SSTBY: begin
                if (rst_src) begin
                    state_nxt = lpmc_pkg::LPMC_RESET;
                end else if (irq_sby_wake) begin
                    state_nxt = lpmc_pkg::LPMC_RUN;
                end else if (trig_rise && snz_en_r) begin
                    state_nxt = lpmc_pkg::LPMC_SNOOZE;
                end
            end
            lpmc_pkg::LPMC_SNOOZE: begin
                if (rst_src) begin
                    state_nxt = lpmc_pkg::LPMC_RESET;
                end else if (irq_sby_wake) begin
                    state_nxt = lpmc_pkg::LPMC_RUN;
                end else if (snooze_end) begin
                    state_nxt = lpmc_pkg::LPMC_SSTBY;
                end
            end
            lpmc_pkg::LPMC_DSTBY: begin
                if (rst_src || irq_dsby_wake) begin
                    state_nxt = lpmc_pkg::LPMC_RESET;
                end
            end
            lpmc_pkg::LPMC_RESET: begin
                if (!rst_src && rst_done) begin
                    state_nxt = lpmc_pkg::LPMC_RUN;
                end
            end
            default: begin
                state_nxt = lpmc_pkg::LPMC_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= lpmc_pkg::LPMC_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // a reset source held on keeps the device in reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt_r <= '0;
        end else if (state_r != lpmc_pkg::LPMC_RESET || rst_src) begin
            rst_cnt_r <= '0;
        end else if (!rst_done) begin
            rst_cnt_r <= rst_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lpm_state  <= lpmc_pkg::LPMC_RUN;
            core_halt  <= 1'b0;
            sys_reset  <= 1'b0;
            irq_resume <= 1'b0;
        end else begin
            lpm_state  <= state_nxt;
            core_halt  <= state_nxt != lpmc_pkg::LPMC_RUN;
            sys_reset  <= state_nxt == lpmc_pkg::LPMC_RESET;
            irq_resume <= state_r != lpmc_pkg::LPMC_RUN
                          && state_r != lpmc_pkg::LPMC_RESET
                          && state_nxt == lpmc_pkg::LPMC_RUN;
        end
    end

    // ------------------------------------------------------------------
    // clocks, module stop and oscillators
    // ------------------------------------------------------------------
    // peripherals keep running in sleep and snooze, not in standby
    assign periph_on = state_r == lpmc_pkg::LPMC_RUN
                       || state_r == lpmc_pkg::LPMC_SLEEP
                       || state_r == lpmc_pkg::LPMC_SNOOZE;

    always_comb begin
        clk_run = {lpmc_pkg::NUM_CLK{periph_on}};
        clk_run[lpmc_pkg::CLK_SYS] = state_r == lpmc_pkg::LPMC_RUN;
    end

    for (genvar g = 0; g < lpmc_pkg::NUM_CLK; g++) begin : g_div
        lpmc_clk_div u_div (
            .clk  (clk),
            .rstn (rstn),
            .run  (clk_run[g]),
            .sel  (div_r[g]),
            .tick (clk_tick[g])
        );
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            module_run <= '0;
        end else begin
            module_run <= ~mstop_r & {lpmc_pkg::NUM_MOD{periph_on}};
        end
    end

    // oscillators the mode does not allow are masked: PLL outside high speed, HOCO, MOCO and main as well in subclock
    always_comb begin
        osc_ok = '1;
        if (opc_mode != lpmc_pkg::LPMC_OPC_HIGH) begin
            osc_ok[lpmc_pkg::OSC_PLL] = 1'b0;
        end
        if (opc_mode == lpmc_pkg::LPMC_OPC_SUB) begin
            osc_ok[lpmc_pkg::OSC_HOCO] = 1'b0;
            osc_ok[lpmc_pkg::OSC_MOCO] = 1'b0;
            osc_ok[lpmc_pkg::OSC_MAIN] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_en <= '0;
        end else begin
            osc_en <= osc_req & osc_ok;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_dsby_wake;
        state_r == lpmc_pkg::LPMC_DSTBY && irq_dsby_wake;
    endsequence

    sequence s_in_reset;
        state_r == lpmc_pkg::LPMC_RESET && sys_reset;
    endsequence

    a_wfi_sleep: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpmc_pkg::LPMC_RUN && wfi && !rst_src && !stby_sel_r
        |=> state_r == lpmc_pkg::LPMC_SLEEP && core_halt)
        else $error("wfi did not enter sleep");

    a_wfi_deep: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpmc_pkg::LPMC_RUN && wfi && !rst_src && stby_sel_r
        && dsby_sel_r |=> state_r == lpmc_pkg::LPMC_DSTBY)
        else $error("wfi did not enter deep standby");

    a_snooze_src: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpmc_pkg::LPMC_SNOOZE && $changed(state_r)
        |-> $past(state_r) == lpmc_pkg::LPMC_SSTBY && $past(snz_en_r))
        else $error("snooze entered from wrong state");

    a_reset_cancel: assert property (@(posedge clk) disable iff (!rstn)
        rst_src && state_r != lpmc_pkg::LPMC_RESET |=> s_in_reset)
        else $error("reset did not cancel mode");

    a_deep_wake: assert property (@(posedge clk) disable iff (!rstn)
        s_dsby_wake |=> s_in_reset ##1 !irq_resume)
        else $error("deep standby wake did not reset");

    a_sleep_resume: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpmc_pkg::LPMC_SLEEP && irq_any && !rst_src
        |=> irq_resume && !core_halt)
        else $error("sleep not resumed by interrupt");

    a_sby_hold: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpmc_pkg::LPMC_SSTBY && !irq_sby_wake && !rst_src
        && !trig_rise |=> state_r == lpmc_pkg::LPMC_SSTBY)
        else $error("standby left without wake source");

    a_osc_sub: assert property (@(posedge clk) disable iff (!rstn)
        opc_mode == lpmc_pkg::LPMC_OPC_SUB && $stable(opc_mode)
        |-> !osc_en[lpmc_pkg::OSC_MAIN] && !osc_en[lpmc_pkg::OSC_PLL])
        else $error("fast oscillator on in subclock mode");

    a_sec_block: assert property (@(posedge clk) disable iff (!rstn)
        cfg_wr[lpmc_pkg::REG_SNOOZE] && sec_attr[lpmc_pkg::REG_SNOOZE]
        && !cfg_secure |=> $stable(snz_en_r))
        else $error("nonsecure write reached secure register");

    a_mstop: assert property (@(posedge clk) disable iff (!rstn)
        state_r == lpmc_pkg::LPMC_SSTBY |=> module_run == '0)
        else $error("module running in standby");

endmodule

// ---- hw/lpmc_pkg.sv ----
/*
 * lpmc_pkg: shared constants and types of the low power mode controller.
 * Assumes a single 125 MHz system clock domain.
 */
package lpmc_pkg;

    // ------------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LPMC_RUN    = 3'h0,
        LPMC_SLEEP  = 3'h1,
        LPMC_SSTBY  = 3'h2,
        LPMC_SNOOZE = 3'h3,
        LPMC_DSTBY  = 3'h4,
        LPMC_RESET  = 3'h5
    } lpmc_state_t;

    // ------------------------------------------------------------------
    // operating power control modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LPMC_OPC_HIGH = 2'h0,
        LPMC_OPC_LOW  = 2'h1,
        LPMC_OPC_SUB  = 2'h3
    } lpmc_opc_t;

    // ------------------------------------------------------------------
    // widths, indices and reset values
    // ------------------------------------------------------------------
    localparam int          NUM_CLK      = 6;
    localparam int          DIV_W        = 3;
    localparam int          DIV_CNT_W    = 7;
    localparam int          NUM_MOD      = 8;
    localparam int          NUM_OSC      = 7;
    localparam int          NUM_REG      = 4;
    // oscillator positions
    localparam int          OSC_PLL      = 0;
    localparam int          OSC_HOCO     = 1;
    localparam int          OSC_MOCO     = 2;
    localparam int          OSC_LOCO     = 3;
    localparam int          OSC_MAIN     = 4;
    localparam int          OSC_SUB      = 5;
    localparam int          OSC_WDT      = 6;
    // clock positions: system, peripheral a..d, flash
    localparam int          CLK_SYS      = 0;
    localparam int          CLK_FLASH    = 5;
    // register group positions for write strobes and attributes
    localparam int          REG_STBY     = 0;
    localparam int          REG_SNOOZE   = 1;
    localparam int          REG_OPC      = 2;
    localparam int          REG_CLK      = 3;
    // reset values
    localparam logic [DIV_W-1:0]   DIV_RST  = 3'h0;
    localparam logic [NUM_MOD-1:0] MSTOP_RST = 8'hFF;
    // time the device is held in the reset state
    localparam int          RST_HOLD_NS  = 64;
    localparam int          CLK_NS       = 8;
    localparam int          RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int          RST_CNT_W    = 4;

endpackage

// ---- hw/lpmc_clk_div.sv ----
/*
 * lpmc_clk_div: divided clock enable generator for one clock.
 * Assumes sel is stable from the register file; ratio is 2**sel.
 */
`timescale 1ns/1ps

module lpmc_clk_div (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    // control
    input  wire logic                        run,
    input  wire logic [lpmc_pkg::DIV_W-1:0]  sel,
    // output
    output logic                             tick
);

    logic [lpmc_pkg::DIV_CNT_W-1:0] cnt_r;
    logic [lpmc_pkg::DIV_CNT_W-1:0] limit;

    assign limit = lpmc_pkg::DIV_CNT_W'((1 << sel) - 1);

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // a stopped clock restarts from zero so the first tick is a full period
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (!run || cnt_r >= limit) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick <= 1'b0;
        end else begin
            tick <= run && (cnt_r >= limit);
        end
    end

endmodule

// ---- test/lpmc_core_model.sv ----
/*
 * lpmc_core_model: processor core and event sources around the controller.
 * Assumes the controller samples these lines on the rising edge of clk and
 * that callers enter each task just after a rising edge.
 */
`timescale 1ns/1ps

module lpmc_core_model (
    // clock and status
    input  wire logic clk,
    input  wire logic irq_resume,
    input  wire logic sys_reset,
    // core and event lines
    output logic      wfi,
    output logic      irq_any,
    output logic      irq_sby_wake,
    output logic      irq_dsby_wake,
    output logic      rst_src,
    output logic      snooze_trig
);
    initial begin
        wfi = 1'b0;
        {irq_dsby_wake, irq_sby_wake, irq_any} = 3'h0;
        rst_src = 1'b0;
        snooze_trig = 1'b0;
    end

    // the handler acknowledges pending sources once the core is back or the device is in reset
    always @(posedge clk) begin
        if (irq_resume === 1'b1 || sys_reset === 1'b1) begin
            #1;
            {irq_dsby_wake, irq_sby_wake, irq_any} = 3'h0;
        end
    end

    task automatic exec_wfi();
        wfi = 1'b1;
        @(posedge clk);
        #1 wfi = 1'b0;
    endtask

    task automatic pend(input logic [2:0] m);
        {irq_dsby_wake, irq_sby_wake, irq_any} = m;
    endtask

    task automatic hold_reset(input int n);
        rst_src = 1'b1;
        repeat (n) @(posedge clk);
        #1 rst_src = 1'b0;
    endtask

    // held long enough for the two stage synchroniser to see it
    task automatic snooze_edge();
        snooze_trig = 1'b1;
        repeat (4) @(posedge clk);
        #1 snooze_trig = 1'b0;
    endtask
endmodule

// ---- test/lpmc_top_tb.sv ----
/*
 * lpmc_top_tb: self-checking bench of the low power mode controller.
 * Assumes lpmc_core_model plays the core; inputs change 1 ns after edges.
 */
`timescale 1ns/1ps

module lpmc_top_tb;
    logic                                 clk, rstn, snooze_end, cfg_secure;
    logic                                 wfi, irq_any, irq_sby_wake;
    logic                                 irq_dsby_wake, rst_src, snooze_trig;
    logic                                 standby_select, deep_standby_select;
    logic                                 snooze_enable;
    logic [1:0]                           power_control_mode;
    logic [lpmc_pkg::NUM_REG-1:0]         cfg_wr, sec_attr;
    logic [lpmc_pkg::DIV_W-1:0]           div_sel [lpmc_pkg::NUM_CLK];
    logic [lpmc_pkg::NUM_MOD-1:0]         module_stop, module_run;
    logic [lpmc_pkg::NUM_OSC-1:0]         osc_req, osc_en;
    logic [lpmc_pkg::NUM_CLK-1:0]         clk_tick;
    lpmc_pkg::lpmc_state_t                lpm_state;
    lpmc_pkg::lpmc_opc_t                  opc_mode;
    logic                                 core_halt, irq_resume, sys_reset;
    int                                   fail_count, cmp_count;

    lpmc_top dut (.clk(clk), .rstn(rstn), .wfi(wfi), .irq_any(irq_any),
        .irq_sby_wake(irq_sby_wake), .irq_dsby_wake(irq_dsby_wake),
        .rst_src(rst_src), .snooze_trig(snooze_trig),
        .snooze_end(snooze_end), .cfg_wr(cfg_wr), .cfg_secure(cfg_secure),
        .sec_attr(sec_attr), .standby_select(standby_select),
        .deep_standby_select(deep_standby_select),
        .snooze_enable(snooze_enable),
        .power_control_mode(power_control_mode), .div_sel(div_sel),
        .module_stop(module_stop), .osc_req(osc_req),
        .lpm_state(lpm_state), .opc_mode(opc_mode), .core_halt(core_halt),
        .irq_resume(irq_resume), .sys_reset(sys_reset),
        .clk_tick(clk_tick), .module_run(module_run), .osc_en(osc_en));

    lpmc_core_model core (.clk(clk), .irq_resume(irq_resume),
        .sys_reset(sys_reset), .wfi(wfi), .irq_any(irq_any),
        .irq_sby_wake(irq_sby_wake), .irq_dsby_wake(irq_dsby_wake),
        .rst_src(rst_src), .snooze_trig(snooze_trig));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // an edge passes after the strobe drops, so a following write never
    // lowers and raises cfg_wr in one time step
    task automatic wr(input int g);
        cfg_wr[g] = 1'b1;
        cyc(1);
        cfg_wr = '0;
        cyc(1);
    endtask

    task automatic wait_st(lpmc_pkg::lpmc_state_t s, input int n);
        for (int i = 0; i < n && lpm_state !== s; i++) cyc(1);
        check("lpm_state", lpm_state, s);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_sleep();
        check("halt", core_halt, 0);
        check("module_run", module_run, 0);
        wr(lpmc_pkg::REG_STBY);
        core.exec_wfi();
        wait_st(lpmc_pkg::LPMC_SLEEP, 4);
        check("halt", core_halt, 1);
        core.pend(3'h1);
        wait_st(lpmc_pkg::LPMC_RUN, 4);
        check("irq_resume", irq_resume, 1);
        core.exec_wfi();
        wait_st(lpmc_pkg::LPMC_SLEEP, 4);
        core.hold_reset(3);
        check("sys_reset", sys_reset, 1);
        wait_st(lpmc_pkg::LPMC_RUN, 12);
    endtask

    task automatic t_standby();
        standby_select = 1'b1;
        snooze_enable = 1'b1;
        wr(lpmc_pkg::REG_STBY);
        wr(lpmc_pkg::REG_SNOOZE);
        core.exec_wfi();
        wait_st(lpmc_pkg::LPMC_SSTBY, 4);
        core.pend(3'h1);
        cyc(4);
        check("lpm_state", lpm_state, lpmc_pkg::LPMC_SSTBY);
        core.snooze_edge();
        wait_st(lpmc_pkg::LPMC_SNOOZE, 6);
        snooze_end = 1'b1;
        cyc(1);
        snooze_end = 1'b0;
        check("lpm_state", lpm_state, lpmc_pkg::LPMC_SSTBY);
        core.snooze_edge();
        wait_st(lpmc_pkg::LPMC_SNOOZE, 6);
        core.pend(3'h3);
        wait_st(lpmc_pkg::LPMC_RUN, 4);
        check("irq_resume", irq_resume, 1);
        snooze_enable = 1'b0;
        wr(lpmc_pkg::REG_SNOOZE);
        core.exec_wfi();
        wait_st(lpmc_pkg::LPMC_SSTBY, 4);
        core.snooze_edge();
        cyc(3);
        check("lpm_state", lpm_state, lpmc_pkg::LPMC_SSTBY);
        core.pend(3'h2);
        wait_st(lpmc_pkg::LPMC_RUN, 4);
    endtask

    task automatic t_deep();
        int n;
        deep_standby_select = 1'b1;
        wr(lpmc_pkg::REG_STBY);
        core.exec_wfi();
        wait_st(lpmc_pkg::LPMC_DSTBY, 4);
        core.pend(3'h2);
        cyc(4);
        check("lpm_state", lpm_state, lpmc_pkg::LPMC_DSTBY);
        core.pend(3'h4);
        wait_st(lpmc_pkg::LPMC_RESET, 4);
        check("irq_resume", irq_resume, 0);
        for (n = 0; n < 20 && lpm_state === lpmc_pkg::LPMC_RESET; n++) cyc(1);
        check("reset_cycles", n, lpmc_pkg::RST_HOLD_CYC);
        check("lpm_state", lpm_state, lpmc_pkg::LPMC_RUN);
    endtask

    task automatic t_clocks();
        int a;
        int b;
        a = 0;
        b = 0;
        div_sel[lpmc_pkg::CLK_SYS] = 3'h2;
        module_stop = 8'hA5;
        wr(lpmc_pkg::REG_CLK);
        cyc(2);
        repeat (16) begin
            a += int'(clk_tick[lpmc_pkg::CLK_SYS]);
            b += int'(clk_tick[lpmc_pkg::CLK_FLASH]);
            cyc(1);
        end
        check("sys_ticks", a, 4);
        check("flash_ticks", b, 16);
        check("module_run", module_run, 8'h5A);
    endtask

    task automatic t_opc();
        foreach (div_sel[i]) div_sel[i] = 3'h7;
        wr(lpmc_pkg::REG_CLK);
        sec_attr[lpmc_pkg::REG_OPC] = 1'b1;
        sec_attr[lpmc_pkg::REG_SNOOZE] = 1'b1;
        cfg_secure = 1'b0;
        snooze_enable = 1'b1;
        wr(lpmc_pkg::REG_SNOOZE);
        power_control_mode = 2'h1;
        wr(lpmc_pkg::REG_OPC);
        cyc(3);
        check("opc_mode", opc_mode, lpmc_pkg::LPMC_OPC_HIGH);
        check("osc_en", osc_en, 7'h7F);
        cfg_secure = 1'b1;
        wr(lpmc_pkg::REG_OPC);
        cyc(3);
        check("opc_mode", opc_mode, lpmc_pkg::LPMC_OPC_LOW);
        check("osc_en", osc_en, 7'h7E);
        power_control_mode = 2'h3;
        wr(lpmc_pkg::REG_OPC);
        cyc(3);
        check("opc_mode", opc_mode, lpmc_pkg::LPMC_OPC_SUB);
        check("osc_en", osc_en, 7'h68);
        power_control_mode = 2'h2;
        wr(lpmc_pkg::REG_OPC);
        cyc(3);
        check("opc_mode", opc_mode, lpmc_pkg::LPMC_OPC_SUB);
    endtask

    // reset in mid-run must restore mode, module stop and oscillators
    task automatic t_rstn();
        osc_req = 7'h2A;
        rstn = 1'b0;
        cyc(2);
        check("opc_mode", opc_mode, lpmc_pkg::LPMC_OPC_HIGH);
        check("osc_en", osc_en, 7'h00);
        rstn = 1'b1;
        cyc(2);
        check("osc_en", osc_en, 7'h2A);
        check("module_run", module_run, 8'h00);
        check("lpm_state", lpm_state, lpmc_pkg::LPMC_RUN);
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        fail_count = 0;
        cmp_count = 0;
        rstn = 1'b0;
        snooze_end = 1'b0;
        cfg_secure = 1'b1;
        cfg_wr = '0;
        sec_attr = '0;
        {standby_select, deep_standby_select, snooze_enable} = 3'h0;
        power_control_mode = 2'h0;
        foreach (div_sel[i]) div_sel[i] = 3'h0;
        module_stop = 8'hFF;
        osc_req = 7'h7F;
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        t_sleep();
        t_clocks();
        t_standby();
        t_deep();
        t_opc();
        t_rstn();
        conclude();
    end

    // the scenarios need well under a thousand cycles
    initial begin
        #(8 * 4000);
        fail_count++;
        conclude();
    end
endmodule
